// ===== design/picfg_defines.vh
// Overview of operation
// [R1] Input mode register holds three 2-bit fields at bits 5-4, 3-2, 1-0.
// [R2] Mode code zero disables the input pin and powers its buffer down.
// [R3] Mode code one enables the pin into the input mux; 2 and 3 reserved.
// [R4] Each two-way pin has a 3-bit drive field; code zero is push-pull.
// [R5] Drive code one is push-pull plus bus keeper; codes 2 to 7 reserved.
// [R6] Register 0x4F holds pin two drive in 6-4, pin one in 2-0.
// [R7] Register 0x50 holds pin four drive in 6-4, pin three in 2-0.
// [R8] Register 0x51 holds pin six drive in 6-4, pin five in 2-0.
// [R9] Register 0x52 holds drive setup of pins seven and eight.
// [R10] Input mode register at 0x4D resets to zero, all inputs disabled.
// [R11] All drive registers reset to zero: push-pull, no keeper.
// [R12] Reserved codes are stored but act like code zero.
`ifndef PICFG_DEFINES_VH
`define PICFG_DEFINES_VH

// ==========================================
// Register indices (byte address is index * 4)
`define PICFG_IDX_IN_MODE 8'h4D
`define PICFG_IDX_DRV_A 8'h4F
`define PICFG_IDX_DRV_B 8'h50
`define PICFG_IDX_DRV_C 8'h51
`define PICFG_IDX_DRV_D 8'h52
`define PICFG_ADDR_W 10
`define PICFG_NUM_REGS 5

// ==========================================
// Field positions
`define PICFG_MODE_W 2
`define PICFG_DRV_W 3
`define PICFG_DRV_LO_LSB 0
`define PICFG_DRV_HI_LSB 4

// ==========================================
// Codes and reset values
`define PICFG_MODE_OFF 2'h0
`define PICFG_MODE_INPUT 2'h1
`define PICFG_DRV_PUSHPULL 3'h0
`define PICFG_DRV_KEEPER 3'h1
`define PICFG_RESET_VAL 8'h00
`define PICFG_IN_MODE_MASK 8'h3F
`define PICFG_DRV_MASK 8'h77

`endif

// ===== design/picfg_reg_mem.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Small register store with registered read data
module picfg_reg_mem (
    input wire clock,
    input wire rst,
    input wire wrEn,
    input wire [2:0] wrIdx,
    input wire [7:0] wrData,
    input wire rdEn,
    input wire [2:0] rdIdx,
    output reg [7:0] rdData,
    output wire [39:0] allRegs
);
    reg [7:0] mem_q [0:4];
    genvar g;

    // Each word resets to zero; flops, not RAM, so all are visible
    generate
        for (g = 0; g < 5; g = g + 1) begin : gWord
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    mem_q[g] <= 8'h00; // see [R10] see [R11]
                end else if (wrEn && wrIdx == g) begin
                    mem_q[g] <= wrData;
                end
            end
            assign allRegs[g*8 +: 8] = mem_q[g];
        end
    endgenerate

    // Read data from a flop
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (rdEn) begin
            rdData <= (rdIdx < 3'd5) ? mem_q[rdIdx] : 8'h00;
        end
    end
endmodule // picfg_reg_mem

`default_nettype wire

// ===== design/picfg_top.v
`timescale 1ns/1ps
`default_nettype none
`include "picfg_defines.vh"

// ==========================================
// Pin input and drive configuration, Avalon-MM slave
module picfg_top (
    input wire clock,
    input wire rst,
    input wire [`PICFG_ADDR_W-1:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output wire [31:0] readdata,
    output wire waitrequest,
    output wire [1:0] response,
    output reg [2:0] inPinEnable,
    output reg [2:0] inPinPowerDown,
    output reg [7:0] drivePushPull,
    output reg [7:0] driveKeeperEn
);
    localparam ST_IDLE = 2'b01;
    localparam ST_DONE = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg badAddr_q;
    wire [39:0] allRegs;
    wire [7:0] rdByte;
    wire [7:0] idxAddr;
    wire [2:0] slot;
    wire hit;
    wire take;
    wire [7:0] mask;
    wire [7:0] wrMasked;
    wire [5:0] modeBits;
    wire [23:0] drvBits;

    // Map a register index to its store slot, 7 when unmapped
    function [2:0] slotOf;
        input [7:0] idx;
        begin
            case (idx)
                `PICFG_IDX_IN_MODE: slotOf = 3'd0;
                `PICFG_IDX_DRV_A: slotOf = 3'd1;
                `PICFG_IDX_DRV_B: slotOf = 3'd2;
                `PICFG_IDX_DRV_C: slotOf = 3'd3;
                `PICFG_IDX_DRV_D: slotOf = 3'd4;
                default: slotOf = 3'd7;
            endcase
        end
    endfunction

    // ==========================================
    // Bus decode
    assign idxAddr = address[9:2];
    assign slot = slotOf(idxAddr);
    assign hit = (slot != 3'd7) && (address[1:0] == 2'b00);
    assign take = (read || write) && state_q == ST_IDLE;
    // Reserved bits written as zero so they read back zero
    assign mask = (slot == 3'd0) ? `PICFG_IN_MODE_MASK : `PICFG_DRV_MASK;
    assign wrMasked = writedata[7:0] & mask; // see [R1] see [R6] see [R7]

    // Two-state handshake: one wait cycle per access
    always @* begin
        case (state_q)
            ST_IDLE: state_d = (read || write) ? ST_DONE : ST_IDLE;
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            badAddr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (take) begin
                badAddr_q <= ~hit;
            end
        end
    end

    assign waitrequest = (read || write) && state_q != ST_DONE;
    assign readdata = {24'h000000, badAddr_q ? 8'h00 : rdByte};
    // Unmapped access answers SLVERR, reads zero, writes dropped
    assign response = (state_q == ST_DONE && badAddr_q) ? 2'b10 : 2'b00;

    picfg_reg_mem uMem (
        .clock(clock),
        .rst(rst),
        .wrEn(take && write && hit && byteenable[0]),
        .wrIdx(slot),
        .wrData(wrMasked),
        .rdEn(take && read),
        .rdIdx(slot),
        .rdData(rdByte),
        .allRegs(allRegs)
    );

    // ==========================================
    // Field extraction, pins one..eight in pairs
    assign modeBits = allRegs[5:0]; // see [R1]
    assign drvBits = {allRegs[38:36], allRegs[34:32], // see [R9]
                      allRegs[30:28], allRegs[26:24], // see [R8]
                      allRegs[22:20], allRegs[18:16], // see [R7]
                      allRegs[14:12], allRegs[10:8]}; // see [R6]

    // Decode registered so pin controls never glitch
    integer i;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            inPinEnable <= 3'b000;
            inPinPowerDown <= 3'b111;
            drivePushPull <= 8'hFF;
            driveKeeperEn <= 8'h00;
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                // Only code one enables; off and reserved power down
                inPinEnable[i] <= modeBits[2*i +: 2] ==
                    `PICFG_MODE_INPUT; // see [R2] see [R3] see [R12]
                inPinPowerDown[i] <= modeBits[2*i +: 2] !=
                    `PICFG_MODE_INPUT; // see [R2] see [R12]
            end
            for (i = 0; i < 8; i = i + 1) begin
                drivePushPull[i] <= 1'b1; // see [R4]
                // Keeper only on code one; reserved codes act as zero
                driveKeeperEn[i] <= drvBits[3*i +: 3] ==
                    `PICFG_DRV_KEEPER; // see [R5] see [R12]
            end
        end
    end
endmodule // picfg_top

`default_nettype wire

// ===== testbench/picfg_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus timing and pin output relations
module picfg_chk (
    input wire clock,
    input wire rst,
    input wire [9:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire [1:0] response,
    input wire [2:0] inPinEnable,
    input wire [2:0] inPinPowerDown,
    input wire [7:0] drivePushPull,
    input wire [7:0] driveKeeperEn
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Write accepted this cycle with byte lane 0 live
    wire wrDone = write && !waitrequest && byteenable[0];
    // Write byte of the previous cycle, for the one-cycle-late decode
    logic [7:0] wdPrev;
    always @(posedge clock) begin
        wdPrev <= writedata[7:0];
    end

    chk_one_wait: assert property (waitrequest |=> !waitrequest)
        else $error("wait state longer than one cycle");
    chk_idle_nowait: assert property (!read && !write |-> !waitrequest)
        else $error("waitrequest without a request");
    chk_power_inv: assert property (inPinPowerDown == ~inPinEnable)
        else $error("power down not inverse of enable");
    chk_push_pull: assert property (drivePushPull == 8'hFF)
        else $error("push-pull drive dropped");
    chk_mode_decode: assert property (wrDone && address == 10'h134 |=>
        inPinEnable == {wdPrev[5:4] == 2'h1,
        wdPrev[3:2] == 2'h1, wdPrev[1:0] == 2'h1})
        else $error("input enable not from mode codes");
    chk_keeper_a: assert property (wrDone && address == 10'h13C |=>
        driveKeeperEn[1:0] == {wdPrev[6:4] == 3'h1,
        wdPrev[2:0] == 3'h1})
        else $error("keeper of pins one and two wrong");
    chk_keeper_d: assert property (wrDone && address == 10'h148 |=>
        driveKeeperEn[7:6] == {wdPrev[6:4] == 3'h1,
        wdPrev[2:0] == 3'h1})
        else $error("keeper of pins seven and eight wrong");
    chk_mode_rsvd: assert property (read && !waitrequest &&
        address == 10'h134 |-> readdata[31:6] == 26'h0)
        else $error("reserved mode bits read nonzero");
    chk_bad_resp: assert property ((read || write) && !waitrequest &&
        address[1:0] != 2'h0 |-> response == 2'h2)
        else $error("misaligned access not refused");
endmodule // picfg_chk
`default_nettype wire

// ===== testbench/picfg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench for the pin setup block
module picfg_top_tb;
    logic clock = 0, rst = 1, read = 0, write = 0;
    logic [9:0] address = 0;
    logic [31:0] writedata = 0, readdata;
    logic [3:0] byteenable = 4'hF;
    logic waitrequest;
    logic [1:0] response, rsp;
    logic [2:0] inPinEnable, inPinPowerDown;
    logic [7:0] drivePushPull, driveKeeperEn, rdv;
    int err_count = 0, num_checks = 0, cyc = 0;

    picfg_top u_picfg_top (.clock, .rst, .address, .read, .write,
        .writedata, .byteenable, .readdata, .waitrequest, .response,
        .inPinEnable, .inPinPowerDown, .drivePushPull, .driveKeeperEn);

    // Clock, and a cycle ceiling so a stuck waitrequest cannot hang us
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end

    // ==========================================
    // Shared compare and bus tasks
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Held until the rising edge that sees waitrequest low; design state
    // moves by non-blocking updates, so values read here are pre-edge
    task automatic bus(logic w, logic [9:0] a, logic [7:0] d, logic [3:0] be);
        @(posedge clock);
        write <= w;
        read <= !w;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        rdv = readdata[7:0];
        rsp = response;
        write <= 0;
        read <= 0;
    endtask
    task automatic rd(logic [9:0] a, logic [7:0] e);
        bus(0, a, 8'h00, 4'hF);
        chk("readback", e, rdv);
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        rd(10'h134, 8'h00);
        for (int i = 1; i < 5; i++)
            rd(10'(10'h138 + 4 * i), 8'h00);
        chk("powerDown", 8'h07, inPinPowerDown);
        chk("keeper", 8'h00, driveKeeperEn);
        chk("pushPull", 8'hFF, drivePushPull);
        $display("test reset done");
    endtask
    task automatic t_mode();
        bus(1, 10'h134, 8'hF9, 4'hF);
        rd(10'h134, 8'h39);
        @(negedge clock);
        chk("inEnable", 8'h01, inPinEnable);
        bus(1, 10'h134, 8'h15, 4'hF);
        bus(1, 10'h134, 8'h00, 4'h0); // lane 0 off, so ignored
        @(negedge clock);
        chk("inEnable", 8'h07, inPinEnable);
        $display("test mode done");
    endtask
    task automatic t_drive();
        for (int i = 1; i < 5; i++)
            bus(1, 10'(10'h138 + 4 * i), 8'hF9, 4'hF);
        for (int i = 1; i < 5; i++)
            rd(10'(10'h138 + 4 * i), 8'h71);
        chk("keeper", 8'h55, driveKeeperEn);
        bus(1, 10'h140, 8'h10, 4'hF);
        @(negedge clock);
        chk("keeper", 8'h59, driveKeeperEn);
        $display("test drive done");
    endtask
    task automatic t_refuse();
        bus(1, 10'h138, 8'hFF, 4'hF); // hole between mode and drive
        chk("response", 8'h02, rsp);
        rd(10'h138, 8'h00);
        bus(0, 10'h135, 8'h00, 4'hF);
        chk("response", 8'h02, rsp);
        $display("test refuse done");
    endtask

    initial begin
        repeat (2) @(posedge clock);
        rst <= 0;
        t_reset();
        t_mode();
        t_drive();
        t_refuse();
        results();
    end
endmodule // picfg_top_tb

bind picfg_top picfg_chk u_picfg_chk (.clock, .rst, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .response,
    .inPinEnable, .inPinPowerDown, .drivePushPull, .driveKeeperEn);
`default_nettype wire
